// ==== rtl/rtcp_pkg.sv ====
package rtcp_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_STATUS      = 8'h30;
   localparam logic [7:0] ADDR_CLOCK_SETUP = 8'h31;
   localparam logic [7:0] ADDR_EVENT_SETUP = 8'h32;
   localparam logic [7:0] SETUP_RESET      = 8'h00;
   localparam logic [7:0] STATUS_RESET     = 8'h10;
   localparam int ES_WDOG   = 7;
   localparam int ES_PDOWN  = 6;
   localparam int ES_PSENSE = 5;
   localparam int ES_ALARM  = 4;
   localparam int CS_RUN    = 7;
   localparam int CS_LINE   = 6;
   localparam int CS_XSEL   = 4;
   localparam int CS_MAINS50 = 3;
   localparam int ST_WDOG   = 6;
   localparam int ST_FIRST  = 4;
   localparam int ST_ANY    = 3;
   localparam int ST_PSI    = 2;
   localparam int ST_ALARM  = 1;
   localparam int ST_CLOCK  = 0;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [1:0] XSEL_4M  = 2'h0;
   localparam logic [1:0] XSEL_2M  = 2'h1;
   localparam logic [1:0] XSEL_1M  = 2'h2;
   localparam logic [1:0] XSEL_32K = 2'h3;
   localparam logic [3:0] TICK_OFF  = 4'h0;
   localparam logic [3:0] TICK_LINE = 4'h6;
   localparam logic [3:0] TICK_2HZ  = 4'hB;
   localparam logic [3:0] TICK_1HZ  = 4'hC;
   localparam logic [3:0] TICK_MIN  = 4'hD;
   localparam logic [3:0] TICK_HOUR = 4'hE;
   localparam logic [3:0] TICK_DAY  = 4'hF;
   localparam int TICK_BIT_OFS = 2;
   localparam int CH_W     = 15;
   localparam int CH_RUN_LO = 9;
   localparam int CH_64HZ  = 8;
   localparam int CH_2HZ   = 13;
   localparam int CH_1HZ   = 14;
   localparam logic [5:0] MAINS_50 = 6'h32;
   localparam logic [5:0] MAINS_60 = 6'h3C;
   localparam logic [5:0] SEC_LAST  = 6'h3B;
   localparam logic [4:0] HOUR_LAST = 5'h17;
   localparam int P_XT = 0;
   localparam int P_MN = 1;
   localparam int P_WIN = 2;
   localparam int P_RAIL = 3;
   localparam int P_CE = 4;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS = 100;
   localparam int ALM_32K_NS = 30500;
   localparam int ALM_2M_NS  = 15300;
   localparam int ALM_4M_NS  = 7600;
   localparam int ALM_1M_NS  = 30500;
   localparam int PFAIL_NS   = 2680000;
   localparam int WDOG_NS    = 15600000;
   localparam int HRST_NS    = 100000;
   localparam int ALM_32K_CYC = (ALM_32K_NS + CLK_NS - 1) / CLK_NS;
   localparam int ALM_2M_CYC  = (ALM_2M_NS + CLK_NS - 1) / CLK_NS;
   localparam int ALM_4M_CYC  = (ALM_4M_NS + CLK_NS - 1) / CLK_NS;
   localparam int ALM_1M_CYC  = (ALM_1M_NS + CLK_NS - 1) / CLK_NS;
   localparam int HRST_CYC    = (HRST_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== rtl/rtcp_core.sv ====
// Function
// - power fail pulls alert low when enabled
// - alarm flag and alert delayed per crystal
// - periodic tick drives alert low
// - alert held low until status read
// - any interrupt ends power-down
// - chip-select low resets serial; watchdog input
// - supply enable raised by rail, interrupt, reset with rail up
// - power-down bit write drops supply enable
// - reset clears setups, dividers; sets first-up
// - rail level at reset end picks mode
// - timebase bit picks mains or crystal seconds
// - series resistor only with slow crystal
// - rail recovery ends power-down, restores outputs
// - stop holds 32Hz to 1Hz stages
// - crystal field picks divider ratio
// - mains bit picks 50 or 60 Hz
// - clock-out field selects output source
// - watchdog needs chip-select toggles else reset
// - power-down asserts host reset, stops clock output
// - power sense blocks mains, flags, re-arm
// - alarm enable gates time match onto alert
// - event setup layout at 32H
// - tick field decodes rates, minute, hour, day
// - status read clears all but power-fail
`timescale 1ns/100ps
`default_nettype none
module rtcp_core
   import rtcp_pkg::*;
#(
   parameter int PFAIL_CYC = (PFAIL_NS + CLK_NS - 1) / CLK_NS,
   parameter int WDOG_CYC  = (WDOG_NS + CLK_NS - 1) / CLK_NS
)
(
   input  wire logic       clk_in,               // 10 MHz
   input  wire logic       rst_n_in,             // power-on reset
   input  wire logic       crystal_ref_in,       // crystal clock level
   input  wire logic       mains_in,             // squared mains input
   input  wire logic       mains_window_in,      // high while mains sits in window
   input  wire logic       system_rail_sense_in, // rail above backup cell rail
   input  wire logic       chip_enable_in,       // chip-select pin
   input  wire logic       alarm_match_in,       // time equals alarm
   input  wire logic       reg_wr_in,            // register write strobe
   input  wire logic       reg_rd_in,            // register read strobe
   input  wire logic [7:0] reg_addr_in,          // register address
   input  wire logic [7:0] reg_wdata_in,         // write data
   output logic      [7:0] reg_rdata_out,        // read data
   output logic            alert_out,            // alert pin level
   output logic            alert_oe_out,         // alert pull-down enable
   output logic            host_reset_out,       // host reset pin level
   output logic            host_reset_oe_out,    // host reset pull-down enable
   output logic            supply_enable_out,    // supply enable
   output logic            clock_out,            // selected square wave
   output logic            second_tick_out,      // one-second update pulse
   output logic            serial_reset_out,     // hold serial logic in reset
   output logic            series_res_out,       // oscillator resistor in
   output logic            battery_mode_out      // backup mode chosen
);
   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic all_ones(input logic [CH_W-1:0] v, input int k);
      logic [CH_W-1:0] m;
      m = {CH_W{1'b1}} >> (CH_W - 1 - k);
      all_ones = (v & m) == m;
   endfunction
   function automatic logic [6:0] pre_mask(input logic [1:0] sel);
      case (sel)
         XSEL_4M:  pre_mask = 7'h7F;
         XSEL_2M:  pre_mask = 7'h3F;
         XSEL_1M:  pre_mask = 7'h1F;
         default:  pre_mask = 7'h00;
      endcase
   endfunction
   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [4:0] sy1_r;
   logic [4:0] sy2_r;
   logic [4:0] prv_r;
   logic [4:0] rise;
   logic [4:0] fall;
   logic       por_r;
   always_ff @(posedge clk_in)
   begin
      sy1_r <= {chip_enable_in, system_rail_sense_in, mains_window_in,
                mains_in, crystal_ref_in};
      sy2_r <= sy1_r;
   end
   // history follows the pin level through reset, so idle-high pins give no false edge
   always_ff @(posedge clk_in)
   begin
      prv_r <= sy2_r;
   end
   // no edge is reported in the power-on cycle, while the history may still be unknown
   assign rise = sy2_r & ~prv_r & {5{!por_r}};
   assign fall = ~sy2_r & prv_r & {5{!por_r}};
   // ----------------------------------------
   // registers and strobes
   // ----------------------------------------
   logic [7:0] cs_r;
   logic [7:0] es_r;
   logic [7:0] st_r;
   logic       off_r;
   logic       ip_r;
   logic       line_mode;
   logic       acc_ok;
   logic       rd_st;
   logic       wr_es;
   logic       pd_wr;
   logic       any_evt;
   logic       wake;
   logic       per_evt;
   logic       al_evt;
   logic       pf_evt;
   logic       wd_evt;
   assign line_mode = cs_r[CS_LINE];
   assign acc_ok = !off_r && sy2_r[P_CE];
   assign rd_st = acc_ok && reg_rd_in && reg_addr_in == ADDR_STATUS;
   assign wr_es = acc_ok && reg_wr_in && reg_addr_in == ADDR_EVENT_SETUP;
   assign pd_wr = wr_es && reg_wdata_in[ES_PDOWN];
   assign any_evt = per_evt || al_evt || pf_evt;
   assign wake = any_evt || rise[P_RAIL];
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         cs_r <= SETUP_RESET;
      else if (acc_ok && reg_wr_in && reg_addr_in == ADDR_CLOCK_SETUP)
         cs_r <= reg_wdata_in;
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         es_r <= SETUP_RESET;
      else
      begin
         if (wr_es)
            es_r <= reg_wdata_in;
         // a wake beats a power-down write in the same cycle, as off_r does
         if (wake)
            es_r[ES_PDOWN] <= 1'b0;
      end
   end
   // ----------------------------------------
   // crystal prescaler and divider chain
   // ----------------------------------------
   logic [6:0]      pre_r;
   logic [CH_W-1:0] ch_r;
   logic [CH_W-1:0] ch_nxt;
   logic            b32k;
   logic            xt_sec;
   // the crystal is sampled at 10 MHz, so a 4 MHz crystal is near the limit
   assign b32k = rise[P_XT] && ((pre_r & pre_mask(cs_r[5:4])) == pre_mask(cs_r[5:4]));
   assign xt_sec = b32k && all_ones(ch_r, CH_1HZ) && cs_r[CS_RUN];
   always_comb
   begin
      ch_nxt = b32k ? ch_r + 1'b1 : ch_r;
      if (!cs_r[CS_RUN])
         ch_nxt[CH_W-1:CH_RUN_LO] = '0;
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         pre_r <= 7'h00;
         ch_r <= '0;
      end
      else
      begin
         if (rise[P_XT])
            pre_r <= pre_r + 1'b1;
         ch_r <= ch_nxt;
      end
   end
   // ----------------------------------------
   // mains divider
   // ----------------------------------------
   logic [5:0] ln_r;
   logic [5:0] ln_last;
   logic       mn_edge;
   logic       ln_sec;
   logic       ln_half;
   logic       ln_1hz;
   logic       ln_2hz;
   logic       sec_evt;
   assign ln_last = (cs_r[CS_MAINS50] ? MAINS_50 : MAINS_60) - 1'b1;
   assign mn_edge = rise[P_MN] && !es_r[ES_PSENSE];
   assign ln_sec = mn_edge && ln_r == ln_last && cs_r[CS_RUN];
   assign ln_half = mn_edge && (ln_r == ln_last || ln_r == (ln_last >> 1));
   assign ln_1hz = ln_r > (ln_last >> 1);
   // uneven 2 Hz duty at both 50 and 60 Hz is accepted
   assign ln_2hz = (ln_r > (ln_last >> 2) && ln_r <= (ln_last >> 1)) ||
                   ln_r > ((ln_last >> 1) + (ln_last >> 2));
   assign sec_evt = line_mode ? ln_sec : xt_sec;
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !cs_r[CS_RUN])
         ln_r <= 6'h00;
      else if (mn_edge)
         ln_r <= (ln_r == ln_last) ? 6'h00 : ln_r + 1'b1;
   end
   // ----------------------------------------
   // minute, hour and day events
   // ----------------------------------------
   logic [5:0] sc_r;
   logic [5:0] mi_r;
   logic [4:0] hr_r;
   logic       min_evt;
   logic       hour_evt;
   logic       day_evt;
   assign min_evt = sec_evt && sc_r == SEC_LAST;
   assign hour_evt = min_evt && mi_r == SEC_LAST;
   assign day_evt = hour_evt && hr_r == HOUR_LAST;
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sc_r <= 6'h00;
         mi_r <= 6'h00;
         hr_r <= 5'h00;
      end
      else
      begin
         if (sec_evt)
            sc_r <= min_evt ? 6'h00 : sc_r + 1'b1;
         if (min_evt)
            mi_r <= hour_evt ? 6'h00 : mi_r + 1'b1;
         if (hour_evt)
            hr_r <= day_evt ? 5'h00 : hr_r + 1'b1;
      end
   end
   // ----------------------------------------
   // periodic tick
   // ----------------------------------------
   always_comb
   begin
      case (es_r[3:0])
         TICK_OFF:  per_evt = 1'b0;
         TICK_MIN:  per_evt = min_evt;
         TICK_HOUR: per_evt = hour_evt;
         TICK_DAY:  per_evt = day_evt;
         TICK_1HZ:  per_evt = sec_evt;
         TICK_2HZ:  per_evt = line_mode ? ln_half : b32k && all_ones(ch_r, CH_2HZ);
         TICK_LINE: per_evt = line_mode ? mn_edge : b32k && all_ones(ch_r, CH_64HZ);
         default:   per_evt = !line_mode && b32k &&
                              all_ones(ch_r, int'(es_r[3:0]) + TICK_BIT_OFS);
      endcase
   end
   // ----------------------------------------
   // alarm delay
   // ----------------------------------------
   logic [8:0] al_r;
   logic       am_d_r;
   logic       al_start;
   logic [8:0] al_dly;
   always_comb
   begin
      case (cs_r[5:4])
         XSEL_4M:  al_dly = 9'(ALM_4M_CYC);
         XSEL_2M:  al_dly = 9'(ALM_2M_CYC);
         XSEL_1M:  al_dly = 9'(ALM_1M_CYC);
         default:  al_dly = 9'(ALM_32K_CYC);
      endcase
   end
   assign al_start = alarm_match_in && !am_d_r && es_r[ES_ALARM];
   assign al_evt = al_r == 9'h001;
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         al_r <= 9'h000;
         am_d_r <= 1'b0;
      end
      else
      begin
         am_d_r <= alarm_match_in;
         if (al_start)
            al_r <= al_dly;
         else if (al_r != 9'h000)
            al_r <= al_r - 1'b1;
      end
   end
   // ----------------------------------------
   // power sense
   // ----------------------------------------
   localparam int PFW = $clog2(PFAIL_CYC + 1);
   logic [PFW-1:0] pf_r;
   logic           ps_done_r;
   assign pf_evt = es_r[ES_PSENSE] && !ps_done_r && sy2_r[P_WIN] &&
                   pf_r == PFW'(PFAIL_CYC - 1);
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !es_r[ES_PSENSE] || !sy2_r[P_WIN] || ps_done_r)
         pf_r <= '0;
      else
         pf_r <= pf_r + 1'b1;
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !es_r[ES_PSENSE])
         ps_done_r <= 1'b0;
      else if (pf_evt)
         ps_done_r <= 1'b1;
   end
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   localparam int WDW = $clog2(WDOG_CYC + 1);
   logic [WDW-1:0] wd_r;
   localparam int HPW = $clog2(HRST_CYC + 1);
   logic [HPW-1:0] hp_r;
   assign wd_evt = es_r[ES_WDOG] && wd_r == WDW'(WDOG_CYC - 1);
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !es_r[ES_WDOG] || rise[P_CE] || fall[P_CE] || wd_evt)
         wd_r <= '0;
      else
         wd_r <= wd_r + 1'b1;
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         hp_r <= '0;
      else if (wd_evt)
         hp_r <= HPW'(HRST_CYC);
      else if (hp_r != '0)
         hp_r <= hp_r - 1'b1;
   end
   // ----------------------------------------
   // status and alert
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         st_r <= STATUS_RESET;
      else
      begin
         if (rd_st)
            st_r <= st_r & (8'h01 << ST_PSI);
         if (wr_es && !reg_wdata_in[ES_PSENSE])
            st_r[ST_PSI] <= 1'b0;
         if (per_evt)
            st_r[ST_CLOCK] <= 1'b1;
         if (al_evt)
            st_r[ST_ALARM] <= 1'b1;
         if (pf_evt)
            st_r[ST_PSI] <= 1'b1;
         if (any_evt)
            st_r[ST_ANY] <= 1'b1;
         if (wd_evt)
            st_r[ST_WDOG] <= 1'b1;
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         ip_r <= 1'b0;
      else if (any_evt)
         ip_r <= 1'b1;
      else if (rd_st)
         ip_r <= 1'b0;
   end
   // ----------------------------------------
   // power-down sequencing
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         off_r <= 1'b1;
         por_r <= 1'b1;
         battery_mode_out <= 1'b0;
      end
      else if (por_r)
      begin
         por_r <= 1'b0;
         battery_mode_out <= !sy2_r[P_RAIL];
         off_r <= !sy2_r[P_RAIL];
      end
      else if (wake)
         off_r <= 1'b0;
      else if (pd_wr || fall[P_RAIL])
         off_r <= 1'b1;
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   logic co_nxt;
   always_comb
   begin
      case (cs_r[2:0])
         3'h0:    co_nxt = sy2_r[P_XT];
         3'h1:    co_nxt = pre_r[0];
         3'h2:    co_nxt = pre_r[1];
         3'h3:    co_nxt = pre_r[2];
         3'h5:    co_nxt = line_mode ? ln_1hz : ch_r[CH_1HZ];
         3'h6:    co_nxt = line_mode ? ln_2hz : ch_r[CH_2HZ];
         3'h7:    co_nxt = line_mode ? sy2_r[P_MN] : ch_r[CH_64HZ];
         default: co_nxt = 1'b0;
      endcase
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         reg_rdata_out <= 8'h00;
         alert_oe_out <= 1'b0;
         host_reset_oe_out <= 1'b1;
         supply_enable_out <= 1'b0;
         clock_out <= 1'b0;
         second_tick_out <= 1'b0;
         serial_reset_out <= 1'b1;
         series_res_out <= 1'b0;
      end
      else
      begin
         if (acc_ok && reg_rd_in)
         begin
            case (reg_addr_in)
               ADDR_STATUS:      reg_rdata_out <= st_r;
               ADDR_CLOCK_SETUP: reg_rdata_out <= cs_r;
               ADDR_EVENT_SETUP: reg_rdata_out <= es_r;
               default:          reg_rdata_out <= 8'h00;
            endcase
         end
         alert_oe_out <= ip_r;
         host_reset_oe_out <= off_r || hp_r != '0;
         supply_enable_out <= !off_r;
         clock_out <= !off_r && co_nxt;
         second_tick_out <= sec_evt;
         serial_reset_out <= !acc_ok;
         series_res_out <= cs_r[5:4] == XSEL_32K;
      end
   end
   // open-drain pins only ever pull low
   assign alert_out = 1'b0;
   assign host_reset_out = 1'b0;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_PFAIL_ALERT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pf_evt |-> ##2 alert_oe_out) else $error("power fail did not pull alert");
   localparam int ALM_4M_DLY = ALM_4M_CYC;
   AST_ALARM_DELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      al_start && cs_r[5:4] == XSEL_4M |-> ##[ALM_4M_DLY:ALM_4M_DLY] al_evt)
      else $error("alarm delay wrong");
   AST_TICK_ALERT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      per_evt |-> ##1 st_r[ST_CLOCK] ##1 alert_oe_out) else $error("tick lost");
   AST_ALERT_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ip_r && !rd_st |=> ip_r) else $error("alert released without read");
   AST_EVT_WAKE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      any_evt && !por_r |-> ##2 supply_enable_out) else $error("interrupt did not wake");
   AST_SERIAL_RST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !sy2_r[P_CE] |=> serial_reset_out) else $error("serial not held in reset");
   AST_PD_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pd_wr && !wake |-> ##2 !supply_enable_out && host_reset_oe_out && !clock_out)
      else $error("power-down write ignored");
   AST_RUN_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cs_r[CS_RUN] |-> !xt_sec && !ln_sec) else $error("second while stopped");
   AST_READ_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_st && !any_evt && !wd_evt && !reg_wr_in |=>
      st_r[1:0] == 2'h0 && st_r[ST_PSI] == $past(st_r[ST_PSI]))
      else $error("status read clear wrong");
endmodule
`default_nettype wire

// ==== verif/rtcp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcp_host_model
(
   input  wire logic       clk_in,    // bench clock
   output logic            ce_out,    // chip select
   output logic            wr_out,    // write strobe
   output logic            rd_out,    // read strobe
   output logic      [7:0] addr_out,  // register address
   output logic      [7:0] wdata_out, // write data
   input  wire logic [7:0] rdata_in   // read data
);
   initial
   begin
      ce_out    = 1'b1;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = 8'h00;
      wdata_out = 8'h00;
   end
   // ----------------------------------------
   // bus cycles, one sampling edge each
   // ----------------------------------------
   // released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in) #1;
      addr_out  = a;
      wdata_out = v;
      wr_out    = 1'b1;
      @(posedge clk_in) #1;
      wr_out    = 1'b0;
      addr_out  = ~a;
      wdata_out = ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in) #1;
      addr_out = a;
      rd_out   = 1'b1;
      @(posedge clk_in) #1;
      rd_out   = 1'b0;
      addr_out = ~a;
      v        = rdata_in;
   endtask
   task automatic ce_set(input logic v);
      ce_out = v;
   endtask
   // select pulse with no transfer services the watchdog
   task automatic ce_pulse();
      @(posedge clk_in) #1;
      ce_out = 1'b0;
      @(posedge clk_in) #1;
      ce_out = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== verif/rtc_interrupt_power_control_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end
module rtc_interrupt_power_control_bench
   import rtcp_pkg::*;
;
   logic       clk_in = 1'b0;
   logic       rst_n  = 1'b0;
   logic       crystal_ref   = 1'b0;
   logic       mains  = 1'b0;
   logic       window = 1'b0;
   logic       rail   = 1'b1;
   logic       alarm  = 1'b0;
   logic       ce, wr, rd, alert, alert_oe, hr, hr_oe, supply, clko, stick, sres, series, batt;
   logic [7:0] addr, wdata, rdata, d, v;
   int         fail_count = 0;
   int         checked    = 0;
   int         ticks      = 0;
   rtcp_core #(.PFAIL_CYC(20), .WDOG_CYC(50)) uut
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .crystal_ref_in(crystal_ref),
      .mains_in(mains),
      .mains_window_in(window),
      .system_rail_sense_in(rail),
      .chip_enable_in(ce),
      .alarm_match_in(alarm),
      .reg_wr_in(wr),
      .reg_rd_in(rd),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_rdata_out(rdata),
      .alert_out(alert),
      .alert_oe_out(alert_oe),
      .host_reset_out(hr),
      .host_reset_oe_out(hr_oe),
      .supply_enable_out(supply),
      .clock_out(clko),
      .second_tick_out(stick),
      .serial_reset_out(sres),
      .series_res_out(series),
      .battery_mode_out(batt)
   );
   rtcp_host_model u_host
   (
      .clk_in(clk_in),
      .ce_out(ce),
      .wr_out(wr),
      .rd_out(rd),
      .addr_out(addr),
      .wdata_out(wdata),
      .rdata_in(rdata)
   );
   // ----------------------------------------
   // clocks, watchdog, helpers
   // ----------------------------------------
   initial
   begin
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) crystal_ref <= #1 ~crystal_ref;
   always @(posedge clk_in) if (stick === 1'b1) ticks <= ticks + 1;
   initial
   begin
      #2000000;
      fail_count++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_hi(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'b1; i++)
         @(posedge clk_in);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic pulse_mains();
      mains = 1'b1;
      step(3);
      mains = 1'b0;
      step(3);
   endtask
   // alarm delay in cycles for each crystal select code
   function automatic int alm_cyc(input int x);
      case (x)
         0: return ALM_4M_CYC;
         1: return ALM_2M_CYC;
         2: return ALM_1M_CYC;
         default: return ALM_32K_CYC;
      endcase
   endfunction
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(79176));
      step(2);
      rst_n = 1'b1;
      step(3);
      rd_chk(ADDR_STATUS, STATUS_RESET);
      rd_chk(ADDR_CLOCK_SETUP, SETUP_RESET);
      rd_chk(ADDR_EVENT_SETUP, SETUP_RESET);
      rd_chk(ADDR_STATUS, 8'h00);
      `CHK({supply, hr_oe, batt, series}, 4'h8)
      `CHK({alert, hr}, 2'h0)
      for (int k = 0; k < 4; k++)
      begin
         v = 8'($urandom);
         u_host.wr(ADDR_CLOCK_SETUP, v);
         rd_chk(ADDR_CLOCK_SETUP, v);
         `CHK(series, v[5:4] == XSEL_32K)
      end
      rd_chk(8'h40, 8'h00);
      u_host.ce_set(1'b0);
      step(4);
      `CHK(sres, 1'b1)
      u_host.wr(ADDR_CLOCK_SETUP, ~v);
      u_host.ce_set(1'b1);
      step(4);
      `CHK(sres, 1'b0)
      rd_chk(ADDR_CLOCK_SETUP, v);
      u_host.wr(ADDR_CLOCK_SETUP, 8'hC8);
      u_host.wr(ADDR_EVENT_SETUP, {4'h0, TICK_LINE});
      pulse_mains();
      wait_hi(alert_oe, 8);
      `CHK(alert_oe, 1'b1)
      rd_chk(ADDR_STATUS, 8'h09);
      step(2);
      `CHK(alert_oe, 1'b0)
      u_host.wr(ADDR_EVENT_SETUP, 8'h00);
      for (int m = 50; m <= 60; m += 10)
      begin
         u_host.wr(ADDR_CLOCK_SETUP, m == 50 ? 8'hC8 : 8'hC0);
         ticks = 0;
         repeat (m) pulse_mains();
         `CHK(ticks, 1)
      end
      u_host.wr(ADDR_CLOCK_SETUP, 8'h80);
      u_host.wr(ADDR_EVENT_SETUP, 8'h20);
      window = 1'b1;
      step(18);
      `CHK(alert_oe, 1'b0)
      wait_hi(alert_oe, 30);
      `CHK(alert_oe, 1'b1)
      window = 1'b0;
      rd_chk(ADDR_STATUS, 8'h0C);
      rd_chk(ADDR_STATUS, 8'h04);
      u_host.wr(ADDR_EVENT_SETUP, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         u_host.wr(ADDR_CLOCK_SETUP, {2'b10, 2'(k), 4'h4});
         u_host.wr(ADDR_EVENT_SETUP, 8'h10);
         step(1);
         alarm = 1'b1;
         step(alm_cyc(k));
         `CHK(alert_oe, 1'b0)
         `CHK(clko, 1'b0)
         wait_hi(alert_oe, 4);
         `CHK(alert_oe, 1'b1)
         alarm = 1'b0;
         rd_chk(ADDR_STATUS, 8'h0A);
      end
      u_host.wr(ADDR_CLOCK_SETUP, 8'hC8);
      u_host.wr(ADDR_EVENT_SETUP, 8'h40);
      step(2);
      `CHK({supply, hr_oe, clko, sres}, 4'h5)
      rail = 1'b0;
      step(4);
      rail = 1'b1;
      wait_hi(supply, 8);
      `CHK({supply, hr_oe}, 2'h2)
      u_host.wr(ADDR_EVENT_SETUP, {4'h4, TICK_LINE});
      step(2);
      `CHK(supply, 1'b0)
      pulse_mains();
      wait_hi(supply, 8);
      `CHK(supply, 1'b1)
      rd_chk(ADDR_STATUS, 8'h09);
      rd_chk(ADDR_EVENT_SETUP, {4'h0, TICK_LINE});
      u_host.wr(ADDR_EVENT_SETUP, 8'h80);
      repeat (6)
      begin
         step(20);
         u_host.ce_pulse();
      end
      `CHK(hr_oe, 1'b0)
      wait_hi(hr_oe, 70);
      `CHK(hr_oe, 1'b1)
      rd_chk(ADDR_STATUS, 8'h40);
      u_host.wr(ADDR_EVENT_SETUP, 8'h00);
      step(990);
      `CHK(hr_oe, 1'b1)
      step(10);
      `CHK(hr_oe, 1'b0)
      rail  = 1'b0;
      rst_n = 1'b0;
      step(3);
      rst_n = 1'b1;
      step(4);
      `CHK({batt, supply, hr_oe}, 3'h5)
      rail = 1'b1;
      wait_hi(supply, 8);
      `CHK({supply, hr_oe}, 2'h2)
      give_verdict();
   end
endmodule
`default_nettype wire
